/* File: bit_band_alias_translator.sv */
`timescale 1ns/10ps
`include "bit_band_regs.svh"
// Core side: req held until ack. Memory side: mem_req held until mem_ack.
// One access in flight; the memory bus is owned from first to last phase.
module bit_band_alias_translator (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  output logic             ack,
  output logic [31:0]      rdata,
  output logic             mem_req,
  output logic             mem_we,
  output logic [31:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  output logic             mem_lock,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata
);
  // Sequencer
  bit_band_pkg::state_t state_r;
  bit_band_pkg::state_t state_nxt;
  // Bit number and store value of the alias access in flight
  logic [4:0]           bit_r;
  logic [4:0]           bit_nxt;
  logic                 wbit_r;
  logic                 wbit_nxt;
  // Memory side
  logic                 mreq_r;
  logic                 mreq_nxt;
  logic                 mwe_r;
  logic                 mwe_nxt;
  logic [31:0]          maddr_r;
  logic [31:0]          maddr_nxt;
  logic [31:0]          mwdata_r;
  logic [31:0]          mwdata_nxt;
  logic                 lock_r;
  logic                 lock_nxt;
  // Core side
  logic                 ack_r;
  logic                 ack_nxt;
  logic [31:0]          rdata_r;
  logic [31:0]          rdata_nxt;
  // Decode and bit handling
  logic                 hit_sram;
  logic                 hit_peri;
  logic                 hit_alias;
  logic                 take;
  logic [31:0]          band_addr;
  logic [31:0]          bit_sel;
  logic [31:0]          new_word;
  logic [31:0]          bit_pick;
  logic                 read_bit;

  assign hit_sram  = (addr & `ALIAS_MASK) == `SRAM_ALIAS_BASE;
  assign hit_peri  = (addr & `ALIAS_MASK) == `PERI_ALIAS_BASE;
  assign hit_alias = hit_sram | hit_peri;
  assign take      = req & (state_r == bit_band_pkg::ST_IDLE);
  // Alias offset/32 is the band byte offset; word aligned, so bits 1:0 of the
  // byte address are zero and the bit number field only picks the bit in the word.
  assign band_addr = (hit_sram ? `SRAM_BAND_BASE : `PERI_BAND_BASE)
                   | {12'h000, addr[`ALIAS_WORD_HI:`ALIAS_WORD_LO], 2'b00};

  // One-hot select shared by the store merge and the load pick, so both
  // paths cost a 32-way decode rather than two barrel shifters
  for (genvar g = 0; g < 32; g++)
  begin : gen_bit
    assign bit_sel[g]  = bit_r == 5'(g);
    assign new_word[g] = bit_sel[g] ? wbit_r : mem_rdata[g];
    assign bit_pick[g] = bit_sel[g] & mem_rdata[g];
  end
  assign read_bit = |bit_pick;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      bit_band_pkg::ST_IDLE:
      begin
        if (req)
        begin
          if (!hit_alias)
          begin
            state_nxt = bit_band_pkg::ST_PASS;
          end
          else if (we)
          begin
            state_nxt = bit_band_pkg::ST_RMW_RD;
          end
          else
          begin
            state_nxt = bit_band_pkg::ST_RD;
          end
        end
      end
      bit_band_pkg::ST_PASS,
      bit_band_pkg::ST_RD,
      bit_band_pkg::ST_RMW_WR:
      begin
        if (mem_ack)
        begin
          state_nxt = bit_band_pkg::ST_DONE;
        end
      end
      bit_band_pkg::ST_RMW_RD:
      begin
        // Straight on to the write phase, no idle slot on the bus
        if (mem_ack)
        begin
          state_nxt = bit_band_pkg::ST_RMW_WR;
        end
      end
      bit_band_pkg::ST_DONE:
      begin
        // One idle cycle lets the core drop req after ack
        state_nxt = bit_band_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r <= bit_band_pkg::ST_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Bit number and store value are only taken for alias hits
  always_comb
  begin
    bit_nxt  = bit_r;
    wbit_nxt = wbit_r;
    if (take && hit_alias)
    begin
      bit_nxt  = addr[`ALIAS_BIT_HI:`ALIAS_BIT_LO];
      wbit_nxt = wdata[0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bit_r  <= 5'h00;
      wbit_r <= 1'b0;
    end
    else
    begin
      bit_r  <= bit_nxt;
      wbit_r <= wbit_nxt;
    end
  end

  always_comb
  begin
    mreq_nxt   = mreq_r;
    mwe_nxt    = mwe_r;
    maddr_nxt  = maddr_r;
    mwdata_nxt = mwdata_r;
    lock_nxt   = lock_r;
    unique case (state_r)
      bit_band_pkg::ST_IDLE:
      begin
        if (req)
        begin
          mreq_nxt = 1'b1;
          if (hit_alias)
          begin
            // Both alias kinds open with a read of the containing word
            maddr_nxt = band_addr;
            mwe_nxt   = 1'b0;
            lock_nxt  = we;
          end
          else
          begin
            // Band and other addresses go out untouched
            maddr_nxt  = addr;
            mwe_nxt    = we;
            mwdata_nxt = wdata;
          end
        end
      end
      bit_band_pkg::ST_PASS,
      bit_band_pkg::ST_RD:
      begin
        if (mem_ack)
        begin
          mreq_nxt = 1'b0;
          mwe_nxt  = 1'b0;
        end
      end
      bit_band_pkg::ST_RMW_RD:
      begin
        if (mem_ack)
        begin
          // Stay requesting and locked: no gap for another master
          mwe_nxt    = 1'b1;
          mwdata_nxt = new_word;
        end
      end
      bit_band_pkg::ST_RMW_WR:
      begin
        if (mem_ack)
        begin
          mreq_nxt = 1'b0;
          mwe_nxt  = 1'b0;
          lock_nxt = 1'b0;
        end
      end
      bit_band_pkg::ST_DONE:
      begin
        mreq_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mreq_r   <= 1'b0;
      mwe_r    <= 1'b0;
      maddr_r  <= `WORD_RESET;
      mwdata_r <= `WORD_RESET;
      lock_r   <= 1'b0;
    end
    else
    begin
      mreq_r   <= mreq_nxt;
      mwe_r    <= mwe_nxt;
      maddr_r  <= maddr_nxt;
      mwdata_r <= mwdata_nxt;
      lock_r   <= lock_nxt;
    end
  end

  // Ack is a one-cycle pulse; rdata holds until the next completion
  always_comb
  begin
    ack_nxt   = 1'b0;
    rdata_nxt = rdata_r;
    unique case (state_r)
      bit_band_pkg::ST_PASS:
      begin
        if (mem_ack)
        begin
          ack_nxt   = 1'b1;
          rdata_nxt = mem_rdata;
        end
      end
      bit_band_pkg::ST_RD:
      begin
        if (mem_ack)
        begin
          ack_nxt   = 1'b1;
          rdata_nxt = {31'h0000_0000, read_bit};
        end
      end
      bit_band_pkg::ST_RMW_WR:
      begin
        // A store through the alias returns an all-zero word
        if (mem_ack)
        begin
          ack_nxt   = 1'b1;
          rdata_nxt = 32'h0000_0000;
        end
      end
      bit_band_pkg::ST_IDLE,
      bit_band_pkg::ST_RMW_RD,
      bit_band_pkg::ST_DONE:
      begin
        ack_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ack_r   <= 1'b0;
      rdata_r <= `WORD_RESET;
    end
    else
    begin
      ack_r   <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign ack       = ack_r;
  assign rdata     = rdata_r;
  assign mem_req   = mreq_r;
  assign mem_we    = mwe_r;
  assign mem_addr  = maddr_r;
  assign mem_wdata = mwdata_r;
  assign mem_lock  = lock_r;
endmodule

/* File: bit_band_regs.svh */
`ifndef BIT_BAND_REGS_SVH
`define BIT_BAND_REGS_SVH
`define SRAM_BAND_BASE  32'h2000_0000
`define SRAM_ALIAS_BASE 32'h2200_0000
`define PERI_BAND_BASE  32'h4000_0000
`define PERI_ALIAS_BASE 32'h4200_0000
`define ALIAS_MASK      32'hFE00_0000
`define ALIAS_WORD_HI   24
`define ALIAS_WORD_LO   7
`define ALIAS_BIT_HI    6
`define ALIAS_BIT_LO    2
`define WORD_RESET      32'h0000_0000
`endif

/* File: bit_band_pkg.sv */
package bit_band_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PASS,
    ST_RD,
    ST_RMW_RD,
    ST_RMW_WR,
    ST_DONE
  } state_t;
endpackage

/* File: bit_band_sva.sv */
`timescale 1ns/10ps
module bit_band_sva (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        req,
  input wire logic        we,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic        ack,
  input wire logic [31:0] rdata,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic        mem_lock,
  input wire logic        mem_ack
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire s_hit = addr[31:25] == 7'h11;
  wire p_hit = addr[31:25] == 7'h21;
  sram_map_a: assert property (mem_req && req && s_hit |->
    mem_addr == {12'h200, addr[24:7], 2'h0}) else $error("sram alias address");
  peri_map_a: assert property (mem_req && req && p_hit |->
    mem_addr == {12'h400, addr[24:7], 2'h0}) else $error("peri alias address");
  pass_thru_a: assert property (mem_req && req && !s_hit && !p_hit |->
    mem_addr == addr && mem_we == we && !mem_lock) else $error("pass access altered");
  lock_alias_a: assert property (mem_req && req && we && (s_hit || p_hit) |-> mem_lock)
    else $error("alias store not locked");
  lock_req_a: assert property (mem_lock |-> mem_req) else $error("lock without bus");
  rmw_seq_a: assert property (mem_lock && mem_ack && !mem_we |=>
    mem_req && mem_we && mem_lock) else $error("write phase missing");
  wr_bit_a: assert property (mem_lock && mem_we |-> mem_wdata[addr[6:2]] == wdata[0])
    else $error("target bit wrong");
  ack_time_a: assert property (mem_ack && !(mem_lock && !mem_we) |=> ack)
    else $error("ack late");
  rd_bit_a: assert property (ack && !we && (s_hit || p_hit) |-> rdata[31:1] == 31'h0)
    else $error("alias read upper bits");
  cover property (ack && we && s_hit);
  cover property (ack && !we && p_hit);
  cover property (ack && !s_hit && !p_hit);
endmodule
bind bit_band_alias_translator bit_band_sva chk (.clk(clk), .rst(rst), .req(req), .we(we),
  .addr(addr), .wdata(wdata), .ack(ack), .rdata(rdata), .mem_req(mem_req), .mem_we(mem_we),
  .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_lock(mem_lock), .mem_ack(mem_ack));

/* File: mem_model.sv */
`timescale 1ns/10ps
module mem_model (
  input  wire logic        clk,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  input  wire logic [1:0]  dly,
  output logic             mem_ack = 1'b0,
  output logic [31:0]      mem_rdata = 32'h0
);
  logic [31:0] m [16];
  logic [1:0]  cnt = 2'h0;
  initial for (int i = 0; i < 16; i++) m[i] = i * 32'h1357_9bdf;
  // Released data toggles so stale values never match by luck
  always @(posedge clk)
    if (mem_req && !mem_ack && cnt == 2'h0)
    begin
      mem_ack <= 1'b1;
      cnt <= dly;
      mem_rdata <= m[mem_addr[5:2]];
      if (mem_we) m[mem_addr[5:2]] <= mem_wdata;
    end
    else
    begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && cnt != 2'h0) cnt <= cnt - 2'h1;
    end
endmodule

/* File: tb_bit_band_alias_translator.sv */
`timescale 1ns/10ps
module tb_bit_band_alias_translator;
  logic clk = 1'b0, rst = 1'b1, req = 1'b0, we = 1'b0, ack, mem_req, mem_we, mem_lock, mem_ack;
  logic [31:0] addr = 32'h0, wdata = 32'h0, rdata, mem_addr, mem_wdata, mem_rdata, r [16];
  logic [1:0]  dly = 2'h0;
  logic [31:0] base [5] = '{32'h2200_0000, 32'h4200_0000, 32'h2000_0000, 32'h4000_0000,
                            32'h6000_0000};
  int mismatches = 0, compares = 0, seed = 32'h4e2e_9c71;
  always #25 clk = ~clk;
  bit_band_alias_translator uut (.clk(clk), .rst(rst), .req(req), .we(we), .addr(addr),
    .wdata(wdata), .ack(ack), .rdata(rdata), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_lock(mem_lock), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  mem_model mem (.clk(clk), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .dly(dly), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  task chk(string n, logic [31:0] s, logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task end_of_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task acc(logic w, logic [31:0] a, logic [31:0] d);
    int k, i, b;
    logic al;
    @(posedge clk) #1;
    req = 1'b1;
    we = w;
    addr = a;
    wdata = d;
    for (k = 0; k < 40 && ack !== 1'b1; k++) @(posedge clk) #1;
    if (ack !== 1'b1)
    begin
      mismatches++;
      end_of_test;
    end
    req = 1'b0;
    al = a[31:25] == 7'h11 || a[31:25] == 7'h21;
    i = al ? a[10:7] : a[5:2];
    b = a[6:2];
    if (al && w) chk("alias write rdata", rdata, 32'h0);
    if (al && !w) chk("alias read rdata", rdata, {31'h0, r[i][b]});
    if (!al && !w) chk("plain read rdata", rdata, r[i]);
    if (w && al) r[i][b] = d[0];
    else if (w) r[i] = d;
  endtask
  initial
  begin
    for (int j = 0; j < 16; j++) r[j] = j * 32'h1357_9bdf;
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    chk("idle outputs", {28'h000_0000, ack, mem_req, mem_we, mem_lock}, 32'h0);
    chk("idle words", mem_addr | mem_wdata | rdata, 32'h0);
    // Top alias words first, then a random mix over all windows
    for (int j = 0; j < 4; j++) acc(~j[0], j < 2 ? 32'h23ff_fffc : 32'h43ff_fffc, 32'h1);
    for (int j = 0; j < 150; j++)
    begin
      dly = 2'($random(seed));
      acc(1'($random(seed)), base[j % 5] + ($random(seed) &
        (j % 5 < 2 ? 32'h01ff_fffc : 32'h000f_fffc)), $random(seed));
    end
    end_of_test;
  end
endmodule
